// ==== bench/coil_model.sv ====
// two-phase coil model: counts coil changes and net full steps
// assumes coil bits {A+,A-,B+,B-} and CW order A+B+, A-B+, A-B-, A+B-
`timescale 1ns/100ps
module coil_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // clear, coils and step counts
    input wire logic clear_i,
    input wire logic [3:0] coil_i,
    output logic [15:0] steps_o,
    output logic signed [15:0] net_o
);
    logic [3:0] last_q;

    function automatic logic [3:0] cw_next(input logic [3:0] p);
        case (p)
            4'ha: return 4'h6;
            4'h6: return 4'h5;
            4'h5: return 4'h9;
            4'h9: return 4'ha;
            default: return 4'hf;
        endcase
    endfunction : cw_next

    always_ff @(posedge clk_i)
    begin
        last_q <= coil_i;
        if (reset_i || clear_i)
        begin
            steps_o <= 16'h0000;
            net_o <= 16'sh0000;
        end
        else if (coil_i != last_q)
        begin
            steps_o <= steps_o + 16'h0001;
            if (coil_i == cw_next(last_q))
                net_o <= net_o + 16'sh0001;
            else if (last_q == cw_next(coil_i))
                net_o <= net_o - 16'sh0001;
        end
    end
endmodule : coil_model

// ==== bench/stepper_demo_mode_controller_bench.sv ====
// self-checking bench of the stepper demonstration controller
// assumes the coil model beside it and shortened tick parameters
`timescale 1ns/100ps
`define CHECK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin \
    mismatches++; $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module stepper_demo_mode_controller_bench;
    import stepper_demo_pkg::*;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic clear = 1'b0;
    panel_t panel_q = '0;
    reg_req_t req_q = '0;
    logic [31:0] rdata;
    logic [3:0] coil;
    lamp_t lamp;
    logic [3:0] disp;
    logic [15:0] steps;
    logic signed [15:0] net;
    int mismatches = 0;
    int samples_checked = 0;
    logic [31:0] v;

    stepper_demo_mode_controller #(.TICK_CYC_P(1), .TICKS_PER_S_P(2000)) dut (
        .clk_i(clk_i), .reset_i(reset_i), .panel_i(panel_q), .reg_req_i(req_q),
        .reg_rdata_o(rdata), .coil_o(coil), .lamp_o(lamp), .step_disp_o(disp));
    coil_model model (.clk_i(clk_i), .reset_i(reset_i), .clear_i(clear),
        .coil_i(coil), .steps_o(steps), .net_o(net));

    initial
    begin
        forever #2 clk_i = ~clk_i;
    end
    // ********************
    // bus and panel tasks
    // ********************
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i) req_q <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i) req_q.rd <= 1'b0;
        #1 d = rdata;
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i) req_q <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i) req_q.wr <= 1'b0;
    endtask : wr
    task automatic press(input logic demo);
        @(posedge clk_i) {panel_q.trigger, panel_q.demo} <= {~demo, demo};
        repeat (40) @(posedge clk_i);
        {panel_q.trigger, panel_q.demo} <= 2'b00;
        repeat (40) @(posedge clk_i);
    endtask : press
    task automatic wait_idle();
        for (int i = 0; i < 30000 && lamp.busy !== 1'b0; i++) @(posedge clk_i);
        #1 `CHECK("idle", 1'b0, lamp.busy)
    endtask : wait_idle
    task automatic mode(input logic [3:0] m);
        @(posedge clk_i) panel_q.mode_sel <= m;
        clear <= 1'b1;
        @(posedge clk_i) clear <= 1'b0;
    endtask : mode
    // ********************
    // scenarios
    // ********************
    task automatic t_reset();
        rd(REG_SEQUENCE, v);
        `CHECK("seq reset", SEQ_RESET, v)
        rd(8'h10, v);
        `CHECK("unmapped", 32'h0, v)
        `CHECK("coil reset", 4'h0, coil)
    endtask : t_reset
    task automatic t_driver();
        mode(MODE_DRIVER);
        @(posedge clk_i) panel_q.ext_step <= 1'b1;
        @(posedge clk_i) panel_q.ext_step <= 1'b0;
        repeat (4) @(posedge clk_i);
        `CHECK("ext steps", 16'h0001, steps)
        `CHECK("ext busy", 1'b0, lamp.busy)
    endtask : t_driver
    task automatic t_cont();
        mode(MODE_CONT);
        panel_q.pot <= 8'hff;
        press(1'b0);
        `CHECK("cont busy", 1'b1, lamp.busy)
        `CHECK("phase lamps", coil, lamp.phase)
        press(1'b0);
        wait_idle();
        rd(REG_POSITION, v);
        `CHECK("cont pos", 32'(net), v)
        `CHECK("cont moved", 1'b1, steps > 16'h0010)
        `CHECK("idle lamps", 4'h0, lamp.phase)
    endtask : t_cont
    task automatic t_demo();
        mode(MODE_INCH);
        press(1'b1);
        `CHECK("demo busy", 1'b1, lamp.busy)
        wait_idle();
        `CHECK("demo steps", 16'd800, steps)
        `CHECK("demo net", 16'sh0000, net)
    endtask : t_demo
    task automatic t_teach_jog();
        wr(REG_POSITION, 32'h0000_0000);
        mode(MODE_TEACH);
        panel_q.dir_ccw <= 1'b0;
        for (int k = 0; k < 2; k++)
        begin
            @(posedge clk_i) panel_q.step_sel <= 4'(k);
            panel_q.phase_sw <= (k == 0) ? 4'h5 : 4'ha;
            press(1'b0);
            `CHECK("disp", 4'(k), disp)
        end
        rd(REG_SEQUENCE, v);
        `CHECK("seq taught", 32'h956a_95a5, v)
        mode(MODE_JOG);
        press(1'b0);
        `CHECK("jog 0", 4'h5, coil)
        `CHECK("start off", 1'b0, lamp.start_phase)
        press(1'b0);
        `CHECK("jog 1", 4'ha, coil)
        `CHECK("start on", 1'b1, lamp.start_phase)
        `CHECK("jog disp", 4'h2, disp)
        rd(REG_STATUS, v);
        `CHECK("status", 12'ha45, v[11:0])
        rd(REG_POSITION, v);
        `CHECK("jog pos", 32'h2, v)
        repeat (6) press(1'b0);
        `CHECK("jog wrap", SEQ_RESET[31:28], coil)
        `CHECK("wrap disp", 4'h0, disp)
    endtask : t_teach_jog
    task automatic t_return();
        mode(MODE_RETURN);
        panel_q.pot <= 8'h00;
        press(1'b0);
        wait_idle();
        rd(REG_POSITION, v);
        `CHECK("home pos", 32'h0, v)
        `CHECK("home steps", 1'b1, steps >= 16'h0002)
    endtask : t_return
    task automatic t_swing_half();
        mode(MODE_SWING);
        press(1'b0);
        wait_idle();
        `CHECK("swing steps", 16'd800, steps)
        `CHECK("swing net", -16'sd200, net)
        mode(MODE_HALF);
        press(1'b0);
        wait_idle();
        `CHECK("half steps", 16'd1600, steps)
        `CHECK("half net", 16'sh0000, net)
    endtask : t_swing_half
    task automatic t_roulette();
        mode(MODE_ROULETTE);
        panel_q.pot <= 8'hff;
        press(1'b0);
        `CHECK("roul busy", 1'b1, lamp.busy)
        press(1'b0);
        wait_idle();
        rd(REG_STATUS, v);
        `CHECK("roul mode", MODE_ROULETTE, v[15:12])
        `CHECK("roul moved", 1'b1, steps > 16'h0010)
    endtask : t_roulette
    task automatic t_inch();
        mode(MODE_INCH);
        press(1'b0);
        wait_idle();
        `CHECK("inch steps", 16'd10, steps)
        `CHECK("inch net", 16'sd10, net)
    endtask : t_inch
    // ********************
    // run control
    // ********************
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : finish_test
    initial
    begin
        repeat (10) @(posedge clk_i);
        reset_i <= 1'b0;
        t_reset();
        t_driver();
        t_cont();
        t_demo();
        t_teach_jog();
        t_return();
        t_swing_half();
        t_roulette();
        t_inch();
        finish_test();
    end
    initial
    begin
        repeat (100000) @(posedge clk_i);
        mismatches++;
        finish_test();
    end
endmodule : stepper_demo_mode_controller_bench

// ==== rtl/stepper_demo_mode_controller.sv ====
// ten-mode stepper demonstration controller with panel inputs and register port
// assumes panel inputs synchronous to clk_i apart from the two push buttons
//
// Overview of operation
// - continuous step rate follows the potentiometer from 20 Hz to 1040 Hz.
// - full-step two-phase drive unless the mode asks for half steps.
// - mode is taken from a selector with positions 0 to 9.
// - step selector 0 to 7 read; display shows current step number.
// - mode 1: eight bursts of 50 CW at 200 Hz, gaps, then 400 CCW.
// - mode 2: each press gives 10 pulses at 1 Hz; CW first eight.
// - mode 3: 300 CW at 100 Hz, hold 1 s, 500 CCW at 200 Hz.
// - mode 4 half step: 600 CW at 200 Hz, hold, 1000 CCW at 400 Hz.
// - mode 5 jog: one pulse at 100 Hz, toggle direction, taught pattern.
// - jog and continuous motion keep the net displacement.
// - mode 6: press starts continuous rotation, next press stops it.
// - mode 7: press steps back to the saved start position.
// - mode 8: press stores phase switches at the selected step number.
// - taught steps 0 to 7 play in order and wrap to 0.
// - mode 9: press starts rotation, next press stops after random delay.
// - mode 0 acts as a plain two-phase stepper driver.
// - one lamp per phase lights while energised during rotation.
// - start-phase lamp lights while A+ and B+ are both on.
// - busy lamp lights while rotation is in progress.
// - direction toggle sets direction where the mode does not.
// - demo push button launches a demonstration sequence.
`timescale 1ns/100ps
module stepper_demo_mode_controller #(
    parameter int unsigned TICK_CYC_P = stepper_demo_pkg::TICK_CYC,
    parameter int unsigned TICKS_PER_S_P = stepper_demo_pkg::TICKS_PER_S
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // operator panel
    input wire stepper_demo_pkg::panel_t panel_i,
    // register port
    input wire stepper_demo_pkg::reg_req_t reg_req_i,
    output logic [31:0] reg_rdata_o,
    // coils and indicators
    output logic [3:0] coil_o,
    output stepper_demo_pkg::lamp_t lamp_o,
    output logic [3:0] step_disp_o
);
    import stepper_demo_pkg::*;

    // ********************
    // timing constants
    // ********************
    localparam logic [31:0] TPS = 32'(TICKS_PER_S_P);
    localparam logic [31:0] MS_TICKS = 32'(TICKS_PER_S_P / MS_PER_S);
    localparam logic [31:0] GAP_TICKS = 32'(TICKS_PER_S_P / MS_PER_S * GAP_MS);
    localparam logic [31:0] HOLD_TICKS = 32'(TICKS_PER_S_P / MS_PER_S * HOLD_MS);
    localparam logic [31:0] DEB_TICKS = 32'(TICKS_PER_S_P / MS_PER_S * DEBOUNCE_MS);
    localparam logic [15:0] TDIV_LAST = 16'(TICK_CYC_P - 1);

    if (TICK_CYC_P < 1 || TICK_CYC_P > 65536 || TICKS_PER_S_P < 2000
        || TICKS_PER_S_P % 1000 != 0)
    begin : g_bad_timing
        $error("unsupported timing parameters");
    end

    // ********************
    // reference tick and buttons
    // ********************
    logic [15:0] tdiv_q;
    logic [1:0] press_w;
    logic [1:0] btn_raw_w;
    wire tick_w = tdiv_q == TDIV_LAST;
    assign btn_raw_w = {panel_i.demo, panel_i.trigger};

    always_ff @(posedge clk_i)
    begin
        if (reset_i || tick_w)
            tdiv_q <= 16'h0000;
        else
            tdiv_q <= tdiv_q + 16'h0001;
    end

    for (genvar i = 0; i < 2; i++)
    begin : g_btn
        logic s0_q;
        logic s1_q;
        logic st_q;
        logic pr_q;
        logic [31:0] dc_q;
        wire diff_w = s1_q != st_q;
        wire done_w = diff_w && tick_w && dc_q >= DEB_TICKS - 32'h1;
        always_ff @(posedge clk_i)
        begin
            if (reset_i)
            begin
                s0_q <= 1'h0;
                s1_q <= 1'h0;
                st_q <= 1'h0;
                pr_q <= 1'h0;
                dc_q <= 32'h0;
            end
            else
            begin
                s0_q <= btn_raw_w[i];
                s1_q <= s0_q;
                dc_q <= (!diff_w || done_w) ? 32'h0 : dc_q + {31'h0, tick_w};
                st_q <= done_w ? s1_q : st_q;
                pr_q <= done_w && s1_q;
            end
        end
        assign press_w[i] = pr_q;
    end

    wire trig_w = press_w[0];
    wire demo_w = press_w[1];

    // ********************
    // motion program
    // ********************
    motion_state_t state_q;
    motion_state_t state_d;
    logic [3:0] run_mode_q;
    logic [3:0] seg_q;
    logic [15:0] cnt_q;
    logic [31:0] wait_q;
    logic [31:0] acc_q;
    logic [2:0] hidx_q;
    logic [2:0] jog_q;
    logic [3:0] phase_q;
    logic [15:0] pos_q;
    logic [3:0] m2_q;
    logic [31:0] seq_q;
    logic [15:0] lfsr_q;
    logic ext_prev_q;
    logic [3:0] disp_q;
    logic [31:0] rdata_q;

    function automatic segment_t program_seg(input logic [3:0] m, input logic [3:0] s,
        input logic m2ccw, input logic [15:0] rcnt, input logic rccw,
        input logic [10:0] phz, input logic dccw);
        segment_t g;
        g = '0;
        case (m)
            MODE_BURST:
                if (s < M1_REPS - 4'h1)
                    g = '{M1_CNT, M1_HZ, 1'h0, 1'h0, WAIT_GAP};
                else if (s == M1_REPS - 4'h1)
                    g = '{M1_CNT, M1_HZ, 1'h0, 1'h0, WAIT_HOLD};
                else
                    g = '{M1_RET_CNT, M1_RET_HZ, 1'h1, 1'h0, WAIT_NONE};
            MODE_INCH:
                g = '{M2_CNT, M2_HZ, m2ccw, 1'h0, WAIT_NONE};
            MODE_SWING:
                if (s == 4'h0)
                    g = '{M3_CNT, M3_HZ, 1'h0, 1'h0, WAIT_HOLD};
                else
                    g = '{M3_RET_CNT, M3_RET_HZ, 1'h1, 1'h0, WAIT_NONE};
            MODE_HALF:
                if (s == 4'h0)
                    g = '{M4_CNT, M4_HZ, 1'h0, 1'h1, WAIT_HOLD};
                else
                    g = '{M4_RET_CNT, M4_RET_HZ, 1'h1, 1'h1, WAIT_NONE};
            MODE_JOG:
                g = '{JOG_CNT, JOG_HZ, dccw, 1'h0, WAIT_NONE};
            MODE_RETURN:
                g = '{rcnt, phz, rccw, 1'h0, WAIT_NONE};
            default:
                g = '0;
        endcase
        return g;
    endfunction : program_seg

    // ********************
    // decoding
    // ********************
    wire [10:0] pot_hz_w = RATE_MIN_HZ + 11'(RATE_STEP_HZ * {3'h0, panel_i.pot});
    wire m2ccw_w = m2_q >= M2_CW_PRESSES;
    wire [15:0] ret_cnt_w = pos_q[15] ? 16'h0000 - pos_q : pos_q;
    wire ret_ccw_w = !pos_q[15];
    wire [3:0] start_mode_w = demo_w ? MODE_BURST : panel_i.mode_sel;
    wire segment_t seg_w = program_seg(run_mode_q, seg_q, m2ccw_w, ret_cnt_w, ret_ccw_w,
        pot_hz_w, panel_i.dir_ccw);
    wire segment_t first_w = program_seg(start_mode_w, 4'h0, m2ccw_w, ret_cnt_w,
        ret_ccw_w, pot_hz_w, panel_i.dir_ccw);
    wire idle_w = state_q == ST_IDLE;
    wire start_w = idle_w && (trig_w || demo_w);
    wire runs_w = start_w && first_w.count != 16'h0000;
    wire cont_start_w = start_w && !demo_w
        && (panel_i.mode_sel == MODE_CONT || panel_i.mode_sel == MODE_ROULETTE);
    wire store_w = idle_w && trig_w && !demo_w && panel_i.mode_sel == MODE_TEACH
        && panel_i.step_sel < SEQ_STEPS;
    wire ext_step_w = idle_w && panel_i.mode_sel == MODE_DRIVER && panel_i.ext_step
        && !ext_prev_q;
    wire moving_w = state_q == ST_RUN || state_q == ST_CONT || state_q == ST_ROUL;
    wire [10:0] rate_w = state_q == ST_RUN ? seg_w.rate_hz : pot_hz_w;
    wire [31:0] acc_sum_w = acc_q + {21'h0, rate_w};
    wire gen_step_w = moving_w && tick_w && acc_sum_w >= TPS;
    wire step_w = gen_step_w || ext_step_w;
    wire ccw_w = state_q == ST_RUN ? seg_w.ccw : panel_i.dir_ccw;
    wire half_w = state_q == ST_RUN && seg_w.half;
    wire jog_w = state_q == ST_RUN && run_mode_q == MODE_JOG;
    wire track_w = gen_step_w && (run_mode_q == MODE_JOG || run_mode_q == MODE_CONT
        || run_mode_q == MODE_RETURN);
    wire last_step_w = state_q == ST_RUN && gen_step_w && cnt_q == 16'h0001;
    wire gap_done_w = state_q == ST_GAP && tick_w && wait_q <= 32'h1;
    wire stop_w = trig_w && state_q == ST_CONT;
    wire roul_done_w = state_q == ST_ROUL && tick_w && wait_q <= 32'h1;
    wire [31:0] wait_ticks_w = seg_w.wait_sel == WAIT_HOLD ? HOLD_TICKS : GAP_TICKS;
    wire [31:0] rand_ticks_w = 32'({22'h0, lfsr_q[9:0]} * MS_TICKS);
    wire [2:0] hstep_w = (half_w || !hidx_q[0]) ? 3'h1 : 3'h2;
    wire [2:0] hnext_w = ccw_w ? hidx_q - hstep_w : hidx_q + hstep_w;
    wire [2:0] jnext_w = ccw_w ? jog_q - 3'h1 : jog_q + 3'h1;
    wire [3:0] seq_pat_w = seq_q[{jog_q, 2'h0} +: 4];
    wire [3:0] half_pat_w = HALF_TABLE[{hnext_w, 2'h0} +: 4];
    wire [15:0] pos_next_w = ccw_w ? pos_q - 16'h0001 : pos_q + 16'h0001;
    wire wr_pos_w = reg_req_i.wr && reg_req_i.addr == REG_POSITION;
    wire wr_seq_w = reg_req_i.wr && reg_req_i.addr == REG_SEQUENCE;
    wire busy_w = !idle_w;
    wire [31:0] status_w = {16'h0000, run_mode_q, phase_q, jog_q, busy_w, panel_i.mode_sel};
    wire [31:0] rd_mux_w = reg_req_i.addr == REG_STATUS ? status_w
        : reg_req_i.addr == REG_POSITION ? {{16{pos_q[15]}}, pos_q}
        : reg_req_i.addr == REG_SEQUENCE ? seq_q : 32'h0;

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
                if (runs_w)
                    state_d = ST_RUN;
                else if (cont_start_w)
                    state_d = ST_CONT;
            ST_RUN:
                if (last_step_w)
                    state_d = seg_w.wait_sel == WAIT_NONE ? ST_IDLE : ST_GAP;
            ST_GAP:
                if (gap_done_w)
                    state_d = ST_RUN;
            ST_CONT:
                if (stop_w)
                    state_d = run_mode_q == MODE_ROULETTE ? ST_ROUL : ST_IDLE;
            ST_ROUL:
                if (roul_done_w)
                    state_d = ST_IDLE;
            default:
                state_d = ST_IDLE;
        endcase
    end

    // ********************
    // sequencing registers
    // ********************
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            state_q <= ST_IDLE;
            run_mode_q <= MODE_DRIVER;
            seg_q <= 4'h0;
            cnt_q <= 16'h0000;
            acc_q <= 32'h0;
            wait_q <= 32'h0;
        end
        else
        begin
            state_q <= state_d;
            run_mode_q <= start_w ? start_mode_w : run_mode_q;
            seg_q <= start_w ? 4'h0 : seg_q + {3'h0, last_step_w};
            if (runs_w)
                cnt_q <= first_w.count;
            else if (gap_done_w)
                cnt_q <= seg_w.count;
            else if (gen_step_w && state_q == ST_RUN)
                cnt_q <= cnt_q - 16'h0001;
            if (runs_w || cont_start_w || gap_done_w)
                acc_q <= TPS - 32'h1;
            else if (gen_step_w)
                acc_q <= acc_sum_w - TPS;
            else if (moving_w && tick_w)
                acc_q <= acc_sum_w;
            if (last_step_w)
                wait_q <= wait_ticks_w;
            else if (stop_w)
                wait_q <= rand_ticks_w;
            else if (tick_w && wait_q != 32'h0)
                wait_q <= wait_q - 32'h1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            phase_q <= 4'h0;
            hidx_q <= 3'h7;
            jog_q <= 3'h0;
            pos_q <= 16'h0000;
        end
        else
        begin
            if (step_w && jog_w)
                phase_q <= seq_pat_w;
            else if (step_w)
                phase_q <= half_pat_w;
            hidx_q <= (step_w && !jog_w) ? hnext_w : hidx_q;
            if (store_w)
                jog_q <= 3'h0;
            else if (step_w && jog_w)
                jog_q <= jnext_w;
            if (track_w)
                pos_q <= pos_next_w;
            else if (wr_pos_w && idle_w)
                pos_q <= reg_req_i.wdata[15:0];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            m2_q <= 4'h0;
            seq_q <= SEQ_RESET;
            lfsr_q <= LFSR_SEED;
            ext_prev_q <= 1'h0;
            disp_q <= 4'h0;
            rdata_q <= 32'h0;
        end
        else
        begin
            if (runs_w && start_mode_w == MODE_INCH && !m2ccw_w)
                m2_q <= m2_q + 4'h1;
            if (wr_seq_w)
                seq_q <= reg_req_i.wdata;
            if (store_w)
                seq_q[{panel_i.step_sel[2:0], 2'h0} +: 4] <= panel_i.phase_sw;
            lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
            ext_prev_q <= panel_i.ext_step;
            disp_q <= panel_i.mode_sel == MODE_TEACH ? panel_i.step_sel
                : {1'h0, jog_q};
            rdata_q <= reg_req_i.rd ? rd_mux_w : 32'h0;
        end
    end

    // ********************
    // outputs
    // ********************
    assign coil_o = phase_q;
    assign lamp_o.phase = phase_q & {4{busy_w}};
    assign lamp_o.start_phase = phase_q[PH_AP] && phase_q[PH_BP];
    assign lamp_o.busy = busy_w;
    assign step_disp_o = disp_q;
    assign reg_rdata_o = rdata_q;

    // ********************
    // assertions
    // ********************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    full_step_pattern_a: assert property (gen_step_w && !half_w && !jog_w
        |=> $countones(phase_q) == 2) else $error("full step not two-phase");
    burst_gap_load_a: assert property (last_step_w && run_mode_q == MODE_BURST
        && seg_q < 4'h7 |=> state_q == ST_GAP && wait_q == GAP_TICKS)
        else $error("burst gap not loaded");
    inch_direction_a: assert property (runs_w && start_mode_w == MODE_INCH
        && m2_q < M2_CW_PRESSES |-> !first_w.ccw ##1 cnt_q == M2_CNT)
        else $error("inch press wrong direction or count");
    pos_track_a: assert property (track_w && !ccw_w
        |=> pos_q == $past(pos_q) + 16'h0001) else $error("position not tracked");
    cont_stop_a: assert property (stop_w && run_mode_q == MODE_CONT
        |=> state_q == ST_IDLE) else $error("continuous run did not stop");
    return_zero_a: assert property (last_step_w && run_mode_q == MODE_RETURN
        |=> pos_q == 16'h0000 && state_q == ST_IDLE) else $error("return missed origin");
    teach_store_a: assert property (store_w
        |=> seq_q[{$past(panel_i.step_sel[2:0]), 2'h0} +: 4] == $past(panel_i.phase_sw))
        else $error("teach entry not stored");
    jog_wrap_a: assert property (step_w && jog_w && !ccw_w && jog_q == 3'h7
        |=> jog_q == 3'h0 && phase_q == $past(seq_q[31:28])) else $error("jog wrap wrong");
    roulette_delay_a: assert property (stop_w && run_mode_q == MODE_ROULETTE
        |=> state_q == ST_ROUL && wait_q == $past(rand_ticks_w))
        else $error("roulette delay not armed");
    busy_cause_a: assert property ($rose(lamp_o.busy)
        |-> $past(trig_w || demo_w)) else $error("busy without a press");
endmodule : stepper_demo_mode_controller

// ==== rtl/stepper_demo_pkg.sv ====
// constants, types and register map of the stepper demonstration controller
// assumes a single 250 MHz clock and a synchronous panel
package stepper_demo_pkg;
    // ********************
    // timing
    // ********************
    localparam int unsigned CLK_HZ = 250_000_000;
    localparam int unsigned TICKS_PER_S = 1_000_000;
    localparam int unsigned TICK_CYC = CLK_HZ / TICKS_PER_S;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned GAP_MS = 200;
    localparam int unsigned HOLD_MS = 1000;
    localparam int unsigned DEBOUNCE_MS = 10;
    localparam logic [10:0] RATE_MIN_HZ = 11'h014;
    localparam logic [10:0] RATE_STEP_HZ = 11'h004;
    localparam logic [10:0] RATE_MAX_HZ = 11'h410;
    // ********************
    // motion programs
    // ********************
    localparam logic [15:0] M1_CNT = 16'h0032;
    localparam logic [10:0] M1_HZ = 11'h0c8;
    localparam logic [3:0] M1_REPS = 4'h8;
    localparam logic [15:0] M1_RET_CNT = 16'h0190;
    localparam logic [10:0] M1_RET_HZ = 11'h12c;
    localparam logic [15:0] M2_CNT = 16'h000a;
    localparam logic [10:0] M2_HZ = 11'h001;
    localparam logic [3:0] M2_CW_PRESSES = 4'h8;
    localparam logic [15:0] M3_CNT = 16'h012c;
    localparam logic [10:0] M3_HZ = 11'h064;
    localparam logic [15:0] M3_RET_CNT = 16'h01f4;
    localparam logic [10:0] M3_RET_HZ = 11'h0c8;
    localparam logic [15:0] M4_CNT = 16'h0258;
    localparam logic [10:0] M4_HZ = 11'h0c8;
    localparam logic [15:0] M4_RET_CNT = 16'h03e8;
    localparam logic [10:0] M4_RET_HZ = 11'h190;
    localparam logic [15:0] JOG_CNT = 16'h0001;
    localparam logic [10:0] JOG_HZ = 11'h064;
    localparam logic [3:0] MODE_DRIVER = 4'h0;
    localparam logic [3:0] MODE_BURST = 4'h1;
    localparam logic [3:0] MODE_INCH = 4'h2;
    localparam logic [3:0] MODE_SWING = 4'h3;
    localparam logic [3:0] MODE_HALF = 4'h4;
    localparam logic [3:0] MODE_JOG = 4'h5;
    localparam logic [3:0] MODE_CONT = 4'h6;
    localparam logic [3:0] MODE_RETURN = 4'h7;
    localparam logic [3:0] MODE_TEACH = 4'h8;
    localparam logic [3:0] MODE_ROULETTE = 4'h9;
    localparam logic [3:0] SEQ_STEPS = 4'h8;
    localparam logic [1:0] WAIT_NONE = 2'h0;
    localparam logic [1:0] WAIT_GAP = 2'h1;
    localparam logic [1:0] WAIT_HOLD = 2'h2;
    // ********************
    // phases, tables, registers
    // ********************
    localparam int PH_AP = 3;
    localparam int PH_BP = 1;
    localparam logic [31:0] HALF_TABLE = 32'h9154_62a8;
    localparam logic [31:0] SEQ_RESET = 32'h956a_956a;
    localparam logic [15:0] LFSR_SEED = 16'hace1;
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_POSITION = 8'h04;
    localparam logic [7:0] REG_SEQUENCE = 8'h08;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RUN = 3'b001,
        ST_GAP = 3'b010,
        ST_CONT = 3'b011,
        ST_ROUL = 3'b100
    } motion_state_t;

    typedef struct packed {
        logic [15:0] count;
        logic [10:0] rate_hz;
        logic ccw;
        logic half;
        logic [1:0] wait_sel;
    } segment_t;

    typedef struct packed {
        logic [3:0] mode_sel;
        logic [3:0] step_sel;
        logic [3:0] phase_sw;
        logic dir_ccw;
        logic [7:0] pot;
        logic trigger;
        logic demo;
        logic ext_step;
    } panel_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic [3:0] phase;
        logic start_phase;
        logic busy;
    } lamp_t;
endpackage : stepper_demo_pkg
